// ==== rt_select_pkg.sv ====
// Purpose: Shared constants and carrier types for the real-time output selector
// Assumes: Register values arrive as plain byte-wide ports, no bus
// Notes:   Field positions refer to bits within each control byte
package rt_select_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SYNC_BEGIN_OFFSET  = 8'h06;
	localparam logic [7:0] SYNC_STOP_OFFSET   = 8'h07;
	localparam logic [7:0] MODE_DELAY_OFFSET  = 8'h11;
	localparam logic [7:0] RT_SELECT_OFFSET   = 8'h12;
	localparam logic [7:0] PORT_CTRL_OFFSET   = 8'h13;
	localparam logic [7:0] VWIN_START_OFFSET  = 8'h15;
	localparam logic [7:0] VWIN_STOP_OFFSET   = 8'h16;
	localparam logic [7:0] VWIN_MSB_OFFSET    = 8'h17;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int OUT_B_INVERT_BIT    = 6;
	localparam int FINE_DELAY_LSB      = 4;
	localparam int OUT_A_INVERT_BIT    = 3;
	localparam int LOCK_SPEED_BIT      = 3;
	localparam int VWIN_START_MSB_BIT  = 0;
	localparam int VWIN_STOP_MSB_BIT   = 1;
	localparam int VWIN_FIELD_POS_BIT  = 2;
	localparam int SEL_A_LSB           = 0;
	localparam int SEL_B_LSB           = 4;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] RT_SELECT_RESET  = 8'h00;
	localparam logic       OUT_RESET        = 1'b0;
	localparam logic       RESERVED_LEVEL   = 1'b0;
	localparam int         SYNC_COARSE_STEP = 8;
	localparam int         SYNC_FINE_STEP   = 2;
	localparam int         ACTIVE_PIXELS    = 720;

	// ------------------------------------------------------------
	// Selection codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SEL_HIGH_Z      = 4'h0,
		SEL_CONST_LOW   = 4'h1,
		SEL_PIX_CLK     = 4'h2,
		SEL_HALF_CLK    = 4'h3,
		SEL_LINE_LOCK   = 4'h4,
		SEL_FRAME_LOCK  = 4'h5,
		SEL_DECODE_LOCK = 4'h6,
		SEL_RSVD_7      = 4'h7,
		SEL_LINE_REF    = 4'h8,
		SEL_LINE_SYNC   = 4'h9,
		SEL_GATED_REF   = 4'ha,
		SEL_RSVD_B      = 4'hb,
		SEL_VERT_SYNC   = 4'hc,
		SEL_VERT_WIN    = 4'hd,
		SEL_ADC_LSB     = 4'he,
		SEL_FIELD_ID    = 4'hf
	} rt_code_t;

	// Internal source signals that feed the selector
	typedef struct packed {
		logic pixel_clock_ref;
		logic half_pixel_clock_ref;
		logic std_line_lock;
		logic fast_line_lock;
		logic vert_lock;
		logic colour_detected;
		logic line_ref;
		logic vertical_sync_pulse;
		logic adc_lsb;
		logic field_id_signal;
		logic [8:0] line_count;
		logic [10:0] pixel_count;
	} rt_sources_t;

	// Window, line-sync, polarity and lock-speed settings
	typedef struct packed {
		logic [7:0] sync_begin_pos;
		logic [7:0] sync_stop_pos;
		logic [7:0] mode_delay;
		logic [7:0] port_ctrl;
		logic [7:0] vwin_start_low;
		logic [7:0] vwin_stop_low;
		logic [7:0] vwin_msb;
	} rt_settings_t;

endpackage : rt_select_pkg

// ==== rt_signal_output_select.sv ====
// Purpose: Routes one of several timing and lock signals to each of two
//          real-time output pins, with per-pin polarity control
// Assumes: Sources are synchronous to ref_clk; counters come from the
//          line timing block; register bytes are written by the host
// Notes:   Tristate appears only as an output enable, never as Z
//
// Summary of operation
// - Output B code from upper nibble; 0=off,1=low
// - Code 2 gives pixel clock reference
// - Code 3 gives half pixel clock reference
// - Code 4 gives line lock flag
// - Code 5: vertical and horizontal lock
// - Code 6: both locks plus colour detected
// - Code 8: active line reference, 720 pixels
// - Line reference continues through vertical blanking
// - Code 9: line sync, begin/stop in eights
// - Fine delay shifts line sync by twos
// - Code 10: line reference ANDed with window
// - Code 12: vertical sync pulse
// - Code 13: vertical window start/stop/field qualified
// - Code 15: field identifier
// - Code 14 ADC LSB on A; reserved on B
// - Output B invert bit inverts selection
// - Lock speed bit picks standard or fast lock
// - Output A code from lower nibble
// - Output A invert bit inverts selection
`timescale 1ns/100ps

module rt_signal_output_select (
	input  wire logic                       ref_clk,
	input  wire logic                       resetn,
	input  wire logic [7:0]                 realtime_output_select,
	input  wire rt_select_pkg::rt_settings_t settings,
	input  wire rt_select_pkg::rt_sources_t  sources,
	output logic                            rt_out_a,
	output logic                            rt_out_a_oe,
	output logic                            rt_out_b,
	output logic                            rt_out_b_oe,
	output logic                            line_sync_pulse,
	output logic                            vertical_window
);

	// ------------------------------------------------------------
	// Decoded control fields
	// ------------------------------------------------------------
	logic [3:0] sel_a;
	logic [3:0] sel_b;
	logic       out_a_invert;
	logic       out_b_invert;
	logic [1:0] sync_fine_delay;
	logic       lock_speed_select;
	logic [8:0] vwin_start_line;
	logic [8:0] vwin_stop_line;
	logic       vwin_field_pos;

	assign sel_a = realtime_output_select[rt_select_pkg::SEL_A_LSB +: 4];
	assign sel_b = realtime_output_select[rt_select_pkg::SEL_B_LSB +: 4];
	assign out_a_invert =
		settings.mode_delay[rt_select_pkg::OUT_A_INVERT_BIT];
	assign out_b_invert =
		settings.mode_delay[rt_select_pkg::OUT_B_INVERT_BIT];
	assign sync_fine_delay =
		settings.mode_delay[rt_select_pkg::FINE_DELAY_LSB +: 2];
	assign lock_speed_select =
		settings.port_ctrl[rt_select_pkg::LOCK_SPEED_BIT];
	assign vwin_start_line = {
		settings.vwin_msb[rt_select_pkg::VWIN_START_MSB_BIT],
		settings.vwin_start_low};
	assign vwin_stop_line = {
		settings.vwin_msb[rt_select_pkg::VWIN_STOP_MSB_BIT],
		settings.vwin_stop_low};
	assign vwin_field_pos =
		settings.vwin_msb[rt_select_pkg::VWIN_FIELD_POS_BIT];

	// ------------------------------------------------------------
	// Lock flags
	// ------------------------------------------------------------
	// Fast lock reacts quicker but chatters on unstable time bases
	logic line_lock_flag;
	logic frame_lock_flag;
	logic decode_lock_flag;

	assign line_lock_flag = lock_speed_select ? sources.fast_line_lock
		: sources.std_line_lock;
	assign frame_lock_flag = line_lock_flag & sources.vert_lock;
	assign decode_lock_flag = frame_lock_flag
		& sources.colour_detected;

	// ------------------------------------------------------------
	// Line sync pulse
	// ------------------------------------------------------------
	// Positions compare in full line clocks so the counter stays simple
	logic [10:0] sync_begin_clk;
	logic [10:0] sync_stop_clk;
	logic [10:0] sync_shift;
	logic [10:0] pix;

	assign sync_shift = 11'(sync_fine_delay) *
		11'(rt_select_pkg::SYNC_FINE_STEP);
	assign sync_begin_clk = 11'(11'(settings.sync_begin_pos) *
		11'(rt_select_pkg::SYNC_COARSE_STEP)) + sync_shift;
	assign sync_stop_clk = 11'(11'(settings.sync_stop_pos) *
		11'(rt_select_pkg::SYNC_COARSE_STEP)) + sync_shift;
	assign pix = sources.pixel_count;

	// Sync high between begin and stop positions
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			line_sync_pulse <= rt_select_pkg::OUT_RESET;
		end else if (pix == sync_begin_clk) begin
			line_sync_pulse <= 1'b1;
		end else if (pix == sync_stop_clk) begin
			line_sync_pulse <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Vertical window
	// ------------------------------------------------------------
	// Window only opens in the field chosen by the field position bit
	logic win_field_ok;

	assign win_field_ok =
		(sources.field_id_signal == vwin_field_pos);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			vertical_window <= rt_select_pkg::OUT_RESET;
		end else if (sources.line_count == vwin_start_line
				&& win_field_ok) begin
			vertical_window <= 1'b1;
		end else if (sources.line_count == vwin_stop_line) begin
			vertical_window <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Active line reference
	// ------------------------------------------------------------
	// Line reference runs on every line, blanking included; it is
	// limited to the 720-pixel window whatever the source gives
	logic line_ref;
	logic gated_line_ref;

	assign line_ref = sources.line_ref
		& (pix < 11'(rt_select_pkg::ACTIVE_PIXELS));
	assign gated_line_ref = line_ref & vertical_window;

	// ------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------
	// Shared decode; is_b marks the second pin for its reserved codes
	function automatic logic pick(input logic [3:0] code,
			input logic is_b);
		logic v;
		v = rt_select_pkg::RESERVED_LEVEL;
		case (rt_select_pkg::rt_code_t'(code))
			rt_select_pkg::SEL_HIGH_Z:      v = 1'b0;
			rt_select_pkg::SEL_CONST_LOW:   v = 1'b0;
			rt_select_pkg::SEL_PIX_CLK:
				v = sources.pixel_clock_ref;
			rt_select_pkg::SEL_HALF_CLK:
				v = sources.half_pixel_clock_ref;
			rt_select_pkg::SEL_LINE_LOCK:   v = line_lock_flag;
			rt_select_pkg::SEL_FRAME_LOCK:  v = frame_lock_flag;
			rt_select_pkg::SEL_DECODE_LOCK: v = decode_lock_flag;
			rt_select_pkg::SEL_LINE_REF:    v = line_ref;
			rt_select_pkg::SEL_LINE_SYNC:   v = line_sync_pulse;
			rt_select_pkg::SEL_GATED_REF:   v = gated_line_ref;
			rt_select_pkg::SEL_VERT_SYNC:
				v = sources.vertical_sync_pulse;
			rt_select_pkg::SEL_VERT_WIN:    v = vertical_window;
			rt_select_pkg::SEL_ADC_LSB:
				v = is_b ? rt_select_pkg::RESERVED_LEVEL
					: sources.adc_lsb;
			rt_select_pkg::SEL_FIELD_ID:
				v = sources.field_id_signal;
			default: v = rt_select_pkg::RESERVED_LEVEL;
		endcase
		return v;
	endfunction : pick

	logic next_a;
	logic next_b;

	// Invert after selection; code 0 stays low so the pin idles clean
	always_comb begin
		next_a = pick(sel_a, 1'b0) ^ out_a_invert;
		next_b = pick(sel_b, 1'b1) ^ out_b_invert;
		if (sel_a == rt_select_pkg::SEL_HIGH_Z) begin
			next_a = 1'b0;
		end
		if (sel_b == rt_select_pkg::SEL_HIGH_Z) begin
			next_b = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Registering removes mux glitches when codes change mid-line
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rt_out_a    <= rt_select_pkg::OUT_RESET;
			rt_out_b    <= rt_select_pkg::OUT_RESET;
			rt_out_a_oe <= 1'b0;
			rt_out_b_oe <= 1'b0;
		end else begin
			rt_out_a    <= next_a;
			rt_out_b    <= next_b;
			rt_out_a_oe <= (sel_a != rt_select_pkg::SEL_HIGH_Z);
			rt_out_b_oe <= (sel_b != rt_select_pkg::SEL_HIGH_Z);
		end
	end

endmodule : rt_signal_output_select

// ==== rt_select_properties.sv ====
// Purpose: Port-level checks for the real-time output selector
// Assumes: One clock, asynchronous active-low reset
// Notes:   Pins follow the inputs sampled one edge earlier
`timescale 1ns/100ps
module rt_select_properties (
	input wire logic			ref_clk,
	input wire logic			resetn,
	input wire logic [7:0]			realtime_output_select,
	input wire rt_select_pkg::rt_settings_t	settings,
	input wire rt_select_pkg::rt_sources_t	sources,
	input wire logic			rt_out_a,
	input wire logic			rt_out_a_oe,
	input wire logic			rt_out_b,
	input wire logic			rt_out_b_oe,
	input wire logic			line_sync_pulse,
	input wire logic			vertical_window
);
	// ------------------------------------------------------------
	// Helper decode
	// ------------------------------------------------------------
	logic [3:0]	sel_a, sel_b;
	logic		ia, ib, lock, live, win_set;
	logic [10:0]	beg, stp;
	// Field split and sync positions in line-locked clocks
	assign sel_a = realtime_output_select[3:0];
	assign sel_b = realtime_output_select[7:4];
	assign ia = settings.mode_delay[3];
	assign ib = settings.mode_delay[6];
	assign lock = settings.port_ctrl[3] ? sources.fast_line_lock
		: sources.std_line_lock;
	assign beg = {settings.sync_begin_pos, 3'h0}
		+ {8'h00, settings.mode_delay[5:4], 1'b0};
	assign stp = {settings.sync_stop_pos, 3'h0}
		+ {8'h00, settings.mode_delay[5:4], 1'b0};
	// Open wins over a close on the same line; checked only where they cannot collide
	assign win_set = sources.field_id_signal == settings.vwin_msb[2]
		&& sources.line_count == {settings.vwin_msb[0], settings.vwin_start_low}
		&& sources.line_count != {settings.vwin_msb[1], settings.vwin_stop_low};
	// No output history exists on the first edge after reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			live <= 1'b0;
		else
			live <= 1'b1;
	end

	default clocking ck @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_off_state: assert property (
		live && $past(sel_b) == 4'h0 |-> !rt_out_b_oe && !rt_out_b)
		else $error("pin b driven while off");
	a_const_low: assert property (
		live && $past(sel_a) == 4'h1 |-> rt_out_a_oe && rt_out_a == $past(ia))
		else $error("pin a constant level wrong");
	a_line_lock: assert property (
		live && $past(sel_a) == 4'h4 |-> rt_out_a == $past(lock ^ ia))
		else $error("pin a line lock wrong");
	a_decode_lock: assert property (
		live && $past(sel_b) == 4'h6 |-> rt_out_b == $past((lock
		& sources.vert_lock & sources.colour_detected) ^ ib))
		else $error("pin b decode lock wrong");
	a_reserved_b: assert property (
		live && $past(sel_b) inside {4'h7, 4'hb, 4'he}
		|-> rt_out_b_oe && rt_out_b == $past(ib))
		else $error("pin b reserved level wrong");
	a_sync_begin: assert property (
		sources.pixel_count == beg |=> line_sync_pulse)
		else $error("line sync did not start");
	a_sync_stop: assert property (
		sources.pixel_count == stp && stp != beg |=> !line_sync_pulse)
		else $error("line sync did not stop");
	a_window_open: assert property (
		win_set |=> vertical_window)
		else $error("vertical window did not open");
endmodule : rt_select_properties

bind rt_signal_output_select rt_select_properties rt_select_properties_inst (
	.ref_clk, .resetn, .realtime_output_select, .settings, .sources,
	.rt_out_a, .rt_out_a_oe, .rt_out_b, .rt_out_b_oe,
	.line_sync_pulse, .vertical_window);

// ==== rt_capture_model.sv ====
// Purpose: Downstream capture logic that samples both real-time pins
// Assumes: The pins carry no pull resistor
// Notes:   An undriven pin shows a level that changes every cycle
`timescale 1ns/100ps
module rt_capture_model (
	input wire logic	ref_clk,
	input wire logic	out_a,
	input wire logic	oe_a,
	input wire logic	out_b,
	input wire logic	oe_b,
	output logic		pin_a,
	output logic		pin_b
);
	// ------------------------------------------------------------
	// Pin resolution
	// ------------------------------------------------------------
	logic	drift = 1'b0;
	// A floating pin must never pass for a steady level
	always @(posedge ref_clk) drift <= ~drift;
	assign pin_a = oe_a ? out_a : drift;
	assign pin_b = oe_b ? out_b : ~drift;
endmodule : rt_capture_model

// ==== rt_signal_output_select_tb.sv ====
// Purpose: Self-checking bench for the real-time output selector
// Assumes: Inputs change by non-blocking assignment at rising edges
// Notes:   Counters are stepped one value per two clocks
`timescale 1ns/100ps
module rt_signal_output_select_tb;
	// ------------------------------------------------------------
	// Stimulus, design and far side
	// ------------------------------------------------------------
	logic				ref_clk = 1'b0;
	logic				resetn = 1'b0;
	logic [7:0]			realtime_output_select = 8'h00;
	rt_select_pkg::rt_settings_t	settings = '0;
	rt_select_pkg::rt_sources_t	sources = '0;
	logic	rt_out_a, rt_out_a_oe, rt_out_b, rt_out_b_oe;
	logic	line_sync_pulse, vertical_window, pin_a, pin_b;
	int	failures = 0;
	int	n_tests = 0;
	rt_signal_output_select rt_signal_output_select_inst (.ref_clk, .resetn,
		.realtime_output_select, .settings, .sources, .rt_out_a,
		.rt_out_a_oe, .rt_out_b, .rt_out_b_oe, .line_sync_pulse,
		.vertical_window);
	rt_capture_model rt_capture_model_inst (.ref_clk, .out_a(rt_out_a),
		.oe_a(rt_out_a_oe), .out_b(rt_out_b), .oe_b(rt_out_b_oe),
		.pin_a, .pin_b);
	initial forever #25 ref_clk = ~ref_clk;

	task automatic check(input logic got, input logic want);
		n_tests++;
		if (got !== want) begin
			failures++;
			$display("unexpected at %0t: got %b want %b", $time, got, want);
		end
	endtask : check

	task automatic conclude();
		if (failures == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	// Pin {oe, level} for one pattern; count-driven codes end in default
	function automatic logic [1:0] want_pin(input logic [3:0] c,
		input logic b, input logic [7:0] v, input logic inv);
		logic l;
		case (c)
			4'h0: return 2'b00;
			4'h2: l = v[7];
			4'h3: l = v[6];
			4'h4: l = v[1] ? v[4] : v[5];
			4'h5: l = (v[1] ? v[4] : v[5]) & v[3];
			4'h6: l = (v[1] ? v[4] : v[5]) & v[3] & v[2];
			4'h8: l = v[1] & ~v[3];
			4'hc: l = v[0];
			4'he: l = ~b & ~v[0];
			4'hf: l = ~v[2];
			default: l = 1'b0;
		endcase
		return {1'b1, l ^ inv};
	endfunction : want_pin

	// Every code but 9, 10 and 13 on both pins, both polarities, varied sources
	task automatic run_codes();
		logic [7:0] pats [6] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h3c, 8'hd4};
		logic [1:0] ea, eb;
		for (int p = 0; p < 6; p++) begin
			for (int c = 0; c < 32; c++) begin
				@(posedge ref_clk);
				realtime_output_select <= {2{c[3:0]}};
				settings.mode_delay <= {1'b0, c[4], 2'b00, ~c[4], 3'h0};
				// Fast lock only with a steady bench time base
				settings.port_ctrl <= {4'h0, pats[p][1], 3'h0};
				// Flags, then line count, then pixel count 719 or 720
				sources <= {pats[p], ~pats[p][0], ~pats[p][2], 9'h000,
					pats[p][3] ? 11'h2d0 : 11'h2cf};
				@(posedge ref_clk);
				#1;
				ea = want_pin(c[3:0], 1'b0, pats[p], ~c[4]);
				eb = want_pin(c[3:0], 1'b1, pats[p], c[4]);
				if (c[3:0] inside {4'h9, 4'ha, 4'hd})
					continue;
				check(rt_out_a_oe, ea[1]);
				check(ea[1] ? pin_a : rt_out_a, ea[0]);
				check(rt_out_b_oe, eb[1]);
				check(eb[1] ? pin_b : rt_out_b, eb[0]);
			end
		end
	endtask : run_codes

	// Line sync at begin 2, stop 4 eighths; window on lines 259 to 265
	// Pin A carries line sync, pin B the window or the gated reference
	task automatic run_counts(input logic [1:0] fine, input logic fp,
		input logic [3:0] code_b);
		logic es, ew, sp, wp;
		logic [10:0] beg;
		beg = 11'h010 + {8'h00, fine, 1'b0};
		es = 1'b0;
		ew = 1'b0;
		@(posedge ref_clk);
		realtime_output_select <= {code_b, 4'h9};
		settings <= '{8'h02, 8'h04, {2'b00, fine, 4'h0}, 8'h00, 8'h03,
			8'h09, {5'h00, fp, 2'b11}};
		sources.field_id_signal <= 1'b1;
		sources.line_ref <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			sources.pixel_count <= 11'(i);
			sources.line_count <= 9'h100 + 9'(i);
			@(posedge ref_clk);
			#1;
			sp = es;
			wp = ew;
			if (11'(i) == beg)
				es = 1'b1;
			if (11'(i) == beg + 11'h010)
				es = 1'b0;
			if (i == 3)
				ew = fp;
			if (i == 9)
				ew = 1'b0;
			if (11'(i) >= beg)
				check(line_sync_pulse, es);
			if (i >= 3)
				check(vertical_window, ew);
			// Pins lag the registered sync and window by one edge
			if (11'(i) > beg)
				check(rt_out_a, sp);
			if (i >= 4)
				check(rt_out_b, wp);
		end
	endtask : run_counts

	// Reset in mid-run clears the enables, release restores the pin A enable
	task automatic run_reset();
		@(posedge ref_clk);
		realtime_output_select <= 8'h11;
		resetn <= 1'b0;
		@(posedge ref_clk);
		#1;
		check(rt_out_a_oe, 1'b0);
		check(rt_out_b_oe, 1'b0);
		@(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		check(rt_out_a_oe, 1'b1);
	endtask : run_reset

	initial begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		run_codes();
		run_counts(2'h1, 1'b1, 4'hd);
		run_counts(2'h3, 1'b0, 4'hd);
		run_counts(2'h2, 1'b1, 4'ha);
		run_reset();
		conclude();
	end

	// Bounds the whole run in case the sequence stalls
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		conclude();
	end
endmodule : rt_signal_output_select_tb
